// ---- rtl/palette_dac_port.sv ----
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
module palette_dac_port #(
  parameter int POR_CYCLES = palette_port_pkg::POR_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host bus
  palette_bus_if.dev bus,
  // Pixel side
  input wire logic [23:0] pixel_in,
  input wire logic palette_select_in_hi,
  input wire logic palette_select_in_lo,
  // Converter side and status
  output logic [29:0] dac_word,
  output logic video_enable,
  output logic normal_mode,
  output logic calibrate_start,
  output logic pixel_phase_b,
  output logic por_active,
  // Divided clock enables
  output logic programmable_clock_output,
  output logic load_output
);
  if (POR_CYCLES < 1 || POR_CYCLES > 65535)
  begin : g_bad_por
    $error("POR_CYCLES out of range");
  end

  typedef enum logic [1:0] {
    ST_POR = 2'b01,
    ST_RUN = 2'b10
  } state_t;

  function automatic logic [9:0] pick(input logic [29:0] w,
                                      input logic [1:0] c);
    case (c)
      2'h0: pick = w[29:20];
      2'h1: pick = w[19:10];
      default: pick = w[9:0];
    endcase
  endfunction : pick

  state_t state_r;
  logic [15:0] por_cnt_r;
  logic [7:0] pointer_r;
  logic [7:0] setup_r;
  logic [7:0] cmd_one_r;
  logic [7:0] cmd_two_r;
  logic [7:0] cmd_three_r;
  logic [1:0] colour_r;
  logic half_r;
  logic [7:0] hi_part_r;
  logic [9:0] stage_red_r;
  logic [9:0] stage_green_r;
  logic [29:0] palette_mem [256];
  logic [23:0] pixel_cap_r;
  logic [29:0] dac_word_r;
  logic [1:0] seq_hist_r;
  logic phase_b_r;
  logic calibrate_r;
  logic [9:0] dev_d_r;
  logic dev_oe_r;
  logic [4:0] prg_cnt_r;
  logic prg_tick_r;
  logic load_cnt_r;
  logic load_tick_r;

  logic access;
  logic wr;
  logic rd;
  logic [1:0] sel;
  logic wide;
  logic tri_step;
  logic ten_bit;
  logic last_part;
  logic [9:0] value_in;
  logic [9:0] value_out;
  logic [9:0] item_out;
  logic [9:0] pix_out;
  logic [29:0] word_sel;
  logic [29:0] lut_word;
  logic selected;
  logic [4:0] prg_last;
  logic load_last;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign access = bus.strobe && (state_r == ST_RUN);
  assign sel = {bus.reg_select_hi, bus.reg_select_lo};
  assign wr = access && !bus.rw;
  assign rd = access && bus.rw;
  assign wide = setup_r[palette_port_pkg::BUS_WIDTH_POS];
  assign tri_step = (sel == palette_port_pkg::SEL_PALETTE) ||
    (rd && sel == palette_port_pkg::SEL_CONTROL &&
     (pointer_r == palette_port_pkg::CTRL_PIXEL_TEST ||
      pointer_r == palette_port_pkg::CTRL_CONV_TEST));
  assign ten_bit = !(sel == palette_port_pkg::SEL_CONTROL &&
    pointer_r == palette_port_pkg::CTRL_PIXEL_TEST);
  assign last_part = !ten_bit || wide || half_r;
  // low bits dropped at 24 bits
  assign value_in = (wide ? bus.data : {hi_part_r, bus.data[1:0]}) &
    {8'hff, {2{setup_r[palette_port_pkg::RESOLUTION_POS]}}};
  assign word_sel = (sel == palette_port_pkg::SEL_PALETTE) ?
    palette_mem[pointer_r] : dac_word_r;
  assign value_out = pick(word_sel, colour_r);
  assign pix_out = pick({pixel_cap_r[23:16], 2'h0, pixel_cap_r[15:8], 2'h0,
    pixel_cap_r[7:0], 2'h0}, colour_r);
  assign item_out = !ten_bit ? {2'h0, pix_out[9:2]} :
    (wide ? value_out : (half_r ? {8'h00, value_out[1:0]} :
    {2'h0, value_out[9:2]}));

  // ----------------------------------------------------------------
  // Power-on reset
  // ----------------------------------------------------------------
  // one microsecond reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_POR;
      por_cnt_r <= 16'h0000;
    end
    else
    begin
      case (state_r)
        ST_POR:
        begin
          por_cnt_r <= por_cnt_r + 16'h0001;
          if (por_cnt_r == 16'(POR_CYCLES - 1))
            state_r <= ST_RUN;
        end
        ST_RUN: state_r <= ST_RUN;
        default: state_r <= ST_POR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pointer, mode and command registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pointer_r <= 8'h00;
      setup_r <= palette_port_pkg::SETUP_RESET;
      cmd_one_r <= palette_port_pkg::CMD_ONE_RESET;
      cmd_two_r <= palette_port_pkg::CMD_TWO_RESET;
      cmd_three_r <= palette_port_pkg::CMD_THREE_RESET;
    end
    else if (wr && sel == palette_port_pkg::SEL_SETUP)
      setup_r <= bus.data[7:0];
    else if (wr && sel == palette_port_pkg::SEL_POINTER)
      pointer_r <= bus.data[7:0];
    else if (wr && sel == palette_port_pkg::SEL_CONTROL)
    begin
      case (pointer_r)
        palette_port_pkg::CTRL_CMD_ONE: cmd_one_r <= bus.data[7:0];
        palette_port_pkg::CTRL_CMD_TWO: cmd_two_r <= bus.data[7:0];
        palette_port_pkg::CTRL_CMD_THREE: cmd_three_r <= bus.data[7:0];
        default: cmd_one_r <= cmd_one_r;
      endcase
    end
    else if (access && sel == palette_port_pkg::SEL_PALETTE &&
             last_part && colour_r == 2'h2)
      pointer_r <= pointer_r + 8'h01;
  end

  // ----------------------------------------------------------------
  // Colour sequence and palette storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      colour_r <= 2'h0;
      half_r <= 1'b0;
      hi_part_r <= 8'h00;
      stage_red_r <= 10'h000;
      stage_green_r <= 10'h000;
    end
    else if (wr && sel == palette_port_pkg::SEL_POINTER)
    begin
      colour_r <= 2'h0;
      half_r <= 1'b0;
    end
    else if (access && tri_step)
    begin
      if (!last_part)
      begin
        half_r <= 1'b1;
        hi_part_r <= bus.data[7:0];
      end
      else
      begin
        half_r <= 1'b0;
        colour_r <= (colour_r == 2'h2) ? 2'h0 : colour_r + 2'h1;
        if (wr && colour_r == 2'h0)
          stage_red_r <= value_in;
        if (wr && colour_r == 2'h1)
          stage_green_r <= value_in;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (wr && sel == palette_port_pkg::SEL_PALETTE && last_part &&
        colour_r == 2'h2)
      palette_mem[pointer_r] <= {stage_red_r, stage_green_r, value_in};
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dev_d_r <= 10'h000;
      dev_oe_r <= 1'b0;
    end
    else
    begin
      dev_oe_r <= rd;
      if (rd)
      begin
        case (sel)
          palette_port_pkg::SEL_SETUP: dev_d_r <= {2'h0, setup_r};
          palette_port_pkg::SEL_POINTER: dev_d_r <= {2'h0, pointer_r};
          palette_port_pkg::SEL_PALETTE: dev_d_r <= item_out;
          default:
          begin
            case (pointer_r)
              palette_port_pkg::CTRL_PIXEL_TEST,
              palette_port_pkg::CTRL_CONV_TEST: dev_d_r <= item_out;
              palette_port_pkg::CTRL_CMD_ONE: dev_d_r <= {2'h0, cmd_one_r};
              palette_port_pkg::CTRL_CMD_TWO: dev_d_r <= {2'h0, cmd_two_r};
              palette_port_pkg::CTRL_CMD_THREE:
                dev_d_r <= {2'h0, cmd_three_r};
              default: dev_d_r <= 10'h000;
            endcase
          end
        endcase
      end
    end
  end

  assign bus.dev_d = dev_d_r;
  assign bus.dev_oe = dev_oe_r;

  // ----------------------------------------------------------------
  // Pixel side
  // ----------------------------------------------------------------
  // palette select match
  assign selected =
    (palette_select_in_hi == setup_r[palette_port_pkg::MATCH_HI_POS]) &&
    (palette_select_in_lo == setup_r[palette_port_pkg::MATCH_LO_POS]);
  assign lut_word = palette_mem[pixel_in[23:16]] &
    {3{8'hff, {2{setup_r[palette_port_pkg::RESOLUTION_POS]}}}};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pixel_cap_r <= 24'h000000;
      dac_word_r <= 30'h00000000;
    end
    else
    begin
      pixel_cap_r <= pixel_in;
      dac_word_r <= selected ? lut_word : 30'h00000000;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq_hist_r <= 2'h0;
      phase_b_r <= 1'b0;
    end
    else if (state_r == ST_POR)
      phase_b_r <= 1'b0;
    else if (wr && sel == palette_port_pkg::SEL_SETUP)
    begin
      seq_hist_r <= {seq_hist_r[0], bus.data[0]};
      phase_b_r <= (bus.data[0] && seq_hist_r == 2'h2) ? 1'b0 : !phase_b_r;
    end
    else
      phase_b_r <= !phase_b_r;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      calibrate_r <= 1'b0;
    else
      calibrate_r <= wr && sel == palette_port_pkg::SEL_SETUP &&
        bus.data[palette_port_pkg::CALIBRATE_POS] &&
        !setup_r[palette_port_pkg::CALIBRATE_POS];
  end

  // ----------------------------------------------------------------
  // Output dividers
  // ----------------------------------------------------------------
  // fixed ratios during reset
  assign prg_last = (state_r == ST_POR) ?
    palette_port_pkg::PRG_DIV_POR_LAST :
    5'((5'h4 << cmd_three_r[palette_port_pkg::PRG_FIELD_POS +: 2]) - 5'h1);
  assign load_last = (state_r == ST_POR) ||
    cmd_three_r[palette_port_pkg::MUX_POS];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prg_cnt_r <= 5'h00;
      prg_tick_r <= 1'b0;
      load_cnt_r <= 1'b0;
      load_tick_r <= 1'b0;
    end
    else
    begin
      prg_tick_r <= (prg_cnt_r >= prg_last);
      prg_cnt_r <= (prg_cnt_r >= prg_last) ? 5'h00 : prg_cnt_r + 5'h01;
      load_tick_r <= (load_cnt_r == load_last);
      load_cnt_r <= (load_cnt_r == load_last) ? 1'b0 : 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dac_word = dac_word_r;
  assign video_enable = selected;
  assign normal_mode = !setup_r[palette_port_pkg::OP_MODE_HI_POS] &&
    setup_r[palette_port_pkg::OP_MODE_LO_POS];
  assign calibrate_start = calibrate_r;
  assign pixel_phase_b = phase_b_r;
  assign por_active = (state_r == ST_POR);
  assign programmable_clock_output = prg_tick_r;
  assign load_output = load_tick_r;
endmodule : palette_dac_port

// ---- rtl/palette_port_pkg.sv ----
// How it works
// - Write code 11 stores mode register byte.
// - Write code 00 loads the address pointer.
// - Write code 10 writes pointer-selected control register.
// - Code 01 writes red, green, blue; pointer increments.
// - Code 01 reads red, green, blue; pointer increments.
// - Narrow bus: high eight bits, then low two.
// - Reset: mode, command two, three ones; one zero.
// - During reset dividers run at thirty-two and two.
// - Power-on reset lasts one microsecond.
// - Host makes no access during power-on reset.
// - Pointer is eight bits, read and write.
// - Mode register top reserved bits read zero.
// - One, zero, one on restart bit restarts phase.
// - Resolution bit picks 30 or 24 bit palette.
// - Bus width bit; narrow mode upper lines zero.
// - Normal mode when op bits are zero, one.
// - Calibrate bit rising edge starts calibration.
// - Selected only when select inputs match bits.
// - Host writes index to pointer before access.
// - Index 00 reads captured 24-bit pixel data.
// - Index 01 reads 30-bit converter input data.
package palette_port_pkg;
  // ----------------------------------------------------------------
  // Select codes, written as {reg_select_hi, reg_select_lo}
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_POINTER = 2'h0;
  localparam logic [1:0] SEL_PALETTE = 2'h1;
  localparam logic [1:0] SEL_CONTROL = 2'h2;
  localparam logic [1:0] SEL_SETUP = 2'h3;
  // ----------------------------------------------------------------
  // Mode register and command register three fields
  // ----------------------------------------------------------------
  localparam int SEQ_RESTART_POS = 0;
  localparam int RESOLUTION_POS = 1;
  localparam int BUS_WIDTH_POS = 2;
  localparam int OP_MODE_LO_POS = 3;
  localparam int OP_MODE_HI_POS = 4;
  localparam int CALIBRATE_POS = 5;
  localparam int MATCH_LO_POS = 6;
  localparam int MATCH_HI_POS = 7;
  localparam int PRG_FIELD_POS = 0;
  localparam int MUX_POS = 6;
  // ----------------------------------------------------------------
  // Reset values and control indices
  // ----------------------------------------------------------------
  localparam logic [7:0] SETUP_RESET = 8'hff;
  localparam logic [7:0] CMD_ONE_RESET = 8'h00;
  localparam logic [7:0] CMD_TWO_RESET = 8'hff;
  localparam logic [7:0] CMD_THREE_RESET = 8'hff;
  localparam logic [7:0] CTRL_PIXEL_TEST = 8'h00;
  localparam logic [7:0] CTRL_CONV_TEST = 8'h01;
  localparam logic [7:0] CTRL_CMD_ONE = 8'h05;
  localparam logic [7:0] CTRL_CMD_TWO = 8'h06;
  localparam logic [7:0] CTRL_CMD_THREE = 8'h07;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int POR_TIME_NS = 1000;
  localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) /
    CLK_PERIOD_NS;
  localparam logic [4:0] PRG_DIV_POR_LAST = 5'h1f;
  // ----------------------------------------------------------------
  // Host controller command port
  // ----------------------------------------------------------------
  localparam logic [3:0] HOST_READ_LAUNCH = 4'h4;
  localparam logic [3:0] HOST_STATUS = 4'h5;
  localparam logic [3:0] HOST_READ_DATA = 4'h6;
endpackage : palette_port_pkg

// ---- rtl/palette_bus_if.sv ----
`timescale 1ns/1ns
interface palette_bus_if;
  logic strobe;
  logic rw;
  logic reg_select_hi;
  logic reg_select_lo;
  logic [9:0] host_d;
  logic host_oe;
  logic [9:0] dev_d;
  logic dev_oe;
  logic [9:0] data;

  // Wire level of the shared data lines; undriven lines read low.
  assign data = dev_oe ? dev_d : (host_oe ? host_d : 10'h000);

  modport host (
    output strobe, rw, reg_select_hi, reg_select_lo, host_d, host_oe,
    input data
  );
  modport dev (
    input strobe, rw, reg_select_hi, reg_select_lo, data,
    output dev_d, dev_oe
  );
endinterface : palette_bus_if

// ---- rtl/palette_host_ctrl.sv ----
`timescale 1ns/1ns
module palette_host_ctrl #(
  parameter int POR_CYCLES = palette_port_pkg::POR_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Software command port
  input wire logic [3:0] addr,
  input wire logic [9:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [9:0] rdata,
  // Device bus
  palette_bus_if.host bus
);
  if (POR_CYCLES < 1 || POR_CYCLES > 65535)
  begin : g_bad_por
    $error("POR_CYCLES out of range");
  end

  logic [15:0] por_cnt_r;
  logic por_wait_r;
  logic strobe_r;
  logic rw_r;
  logic [1:0] sel_r;
  logic [9:0] host_d_r;
  logic host_oe_r;
  logic read_wait_r;
  logic [9:0] rd_data_r;
  logic done_r;
  logic refused_r;
  logic [9:0] rdata_r;
  logic busy;
  logic cmd;
  logic status_rd;

  // A command right after a read launch would drive the lines while the
  // device answers, so it is refused rather than queued.
  assign busy = por_wait_r || (strobe_r && rw_r);
  assign cmd = wr && (addr <= palette_port_pkg::HOST_READ_LAUNCH);
  assign status_rd = rd && (addr == palette_port_pkg::HOST_STATUS);

  // ----------------------------------------------------------------
  // Power-on wait
  // ----------------------------------------------------------------
  // hold off accesses
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      por_cnt_r <= 16'h0000;
      por_wait_r <= 1'b1;
    end
    else if (por_wait_r)
    begin
      por_cnt_r <= por_cnt_r + 16'h0001;
      if (por_cnt_r == 16'(POR_CYCLES - 1))
        por_wait_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strobe_r <= 1'b0;
      rw_r <= 1'b0;
      sel_r <= 2'h0;
      host_d_r <= 10'h000;
      host_oe_r <= 1'b0;
    end
    else if (cmd && !busy)
    begin
      strobe_r <= 1'b1;
      rw_r <= (addr == palette_port_pkg::HOST_READ_LAUNCH);
      sel_r <= (addr == palette_port_pkg::HOST_READ_LAUNCH) ?
        wdata[1:0] : addr[1:0];
      host_d_r <= wdata;
      host_oe_r <= (addr != palette_port_pkg::HOST_READ_LAUNCH);
    end
    else
    begin
      strobe_r <= 1'b0;
      host_oe_r <= 1'b0;
    end
  end

  assign bus.strobe = strobe_r;
  assign bus.rw = rw_r;
  assign bus.reg_select_hi = sel_r[1];
  assign bus.reg_select_lo = sel_r[0];
  assign bus.host_d = host_d_r;
  assign bus.host_oe = host_oe_r;

  // ----------------------------------------------------------------
  // Read capture and status
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      read_wait_r <= 1'b0;
      rd_data_r <= 10'h000;
      done_r <= 1'b0;
      refused_r <= 1'b0;
    end
    else
    begin
      read_wait_r <= strobe_r && rw_r;
      if (read_wait_r)
        rd_data_r <= bus.data;
      // Setting wins over the clear of a status read.
      done_r <= read_wait_r || (done_r && !status_rd);
      refused_r <= (cmd && busy) || (refused_r && !status_rd);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= 10'h000;
    else if (status_rd)
      rdata_r <= {7'h00, por_wait_r, refused_r, done_r};
    else if (rd && addr == palette_port_pkg::HOST_READ_DATA)
      rdata_r <= rd_data_r;
    else if (rd)
      rdata_r <= 10'h000;
  end

  assign rdata = rdata_r;
endmodule : palette_host_ctrl

// ---- verif/palette_port_chk.sv ----
`timescale 1ns/1ns
module palette_port_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus lines between the two ends
  input wire logic strobe,
  input wire logic rw,
  input wire logic reg_select_hi,
  input wire logic reg_select_lo,
  input wire logic [9:0] host_d,
  input wire logic host_oe,
  input wire logic [9:0] dev_d,
  input wire logic dev_oe,
  input wire logic [9:0] data
);
  logic [1:0] sel;
  logic [7:0] setup_r;
  logic wide;
  logic full_res;
  logic idx_plain_r;
  assign sel = {reg_select_hi, reg_select_lo};
  assign wide = setup_r[palette_port_pkg::BUS_WIDTH_POS];
  assign full_res = setup_r[palette_port_pkg::RESOLUTION_POS];

  // Shadow of the mode byte taken from the wire, so reads are judged
  // without looking inside the device.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      setup_r <= palette_port_pkg::SETUP_RESET;
    else if (strobe && !rw && sel == 2'h3)
      setup_r <= data[7:0];
  end

  // Index 01 reads ten-bit converter data, so the upper-line check is
  // held off there and wherever a palette step may have moved the index.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      idx_plain_r <= 1'b1;
    else if (strobe && !rw && sel == 2'h0)
      idx_plain_r <= data[7:0] != palette_port_pkg::CTRL_CONV_TEST;
    else if (strobe && sel == 2'h1)
      idx_plain_r <= 1'b0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_read_answer: assert property (
    strobe && rw |=> dev_oe)
    else $error("device did not answer a read strobe");
  chk_answer_once: assert property (
    dev_oe |=> !dev_oe)
    else $error("device drove the bus for more than one cycle");
  chk_write_drive: assert property (
    strobe && !rw |-> host_oe && !dev_oe && data == host_d)
    else $error("write strobe without the host alone on the bus");
  chk_narrow_upper: assert property (
    dev_oe && !wide |-> dev_d[9:8] == 2'h0)
    else $error("upper data lines not zero on a narrow bus");
  chk_setup_read: assert property (
    strobe && rw && sel == 2'h3 |=> dev_d == {2'h0, setup_r})
    else $error("mode read does not match the last mode write");
  chk_reg_upper: assert property (
    strobe && rw && (sel[1] == sel[0] || (sel == 2'h2 && idx_plain_r))
    |=> dev_d[9:8] == 2'h0)
    else $error("register read drove the upper data lines");
  chk_low_res: assert property (
    strobe && rw && sel == 2'h1 && wide && !full_res
    |=> dev_d[1:0] == 2'h0)
    else $error("low palette bits not zero at 24-bit resolution");
  chk_no_clash: assert property (
    !(dev_oe && host_oe))
    else $error("both ends drive the data lines");

  cover property (strobe && rw && sel == 2'h1);
  cover property (strobe && !rw && sel == 2'h2);
  cover property (dev_oe && !wide);
endmodule : palette_port_chk

// ---- verif/palette_dac_host_port_test.sv ----
`timescale 1ns/1ns
module palette_dac_host_port_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [9:0] wdata = 10'h000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [9:0] rdata;
  logic [23:0] pixel_in = 24'h103456;
  logic ps_hi = 1'b1;
  logic ps_lo = 1'b1;
  logic [29:0] dac_word;
  logic video_enable, normal_mode, calibrate_start, por_active, load_output;
  logic phase_b, prg_out;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  int cal_pulses = 0;

  always #50 clk = ~clk;

  palette_bus_if link ();
  palette_host_ctrl i_palette_host_ctrl (.clk(clk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .bus(link));
  palette_dac_port i_palette_dac_port (.clk(clk), .rst_n(rst_n), .bus(link),
    .pixel_in(pixel_in), .palette_select_in_hi(ps_hi),
    .palette_select_in_lo(ps_lo), .dac_word(dac_word),
    .video_enable(video_enable), .normal_mode(normal_mode),
    .calibrate_start(calibrate_start), .pixel_phase_b(phase_b),
    .por_active(por_active), .programmable_clock_output(prg_out),
    .load_output(load_output));
  palette_port_chk i_palette_port_chk (.clk(clk), .rst_n(rst_n),
    .strobe(link.strobe), .rw(link.rw), .reg_select_hi(link.reg_select_hi),
    .reg_select_lo(link.reg_select_lo), .host_d(link.host_d),
    .host_oe(link.host_oe), .dev_d(link.dev_d), .dev_oe(link.dev_oe),
    .data(link.data));

  // A hang is cut short well beyond the few hundred cycles the run needs.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (calibrate_start === 1'b1)
      cal_pulses <= cal_pulses + 1;
    if (cycles == 20000)
    begin
      n_fail = n_fail + 1;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [29:0] seen,
    input logic [29:0] exp);
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic sw_wr(input logic [3:0] a, input logic [9:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : sw_wr

  task automatic sw_rd(input logic [3:0] a, output logic [9:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : sw_rd

  // Host offsets 0 to 3 carry the select code itself.
  task automatic wreg(input logic [1:0] c, input logic [9:0] d);
    sw_wr({2'h0, c}, d);
  endtask : wreg

  task automatic expect_rd(input logic [1:0] c, input logic [9:0] exp,
    input string what);
    logic [9:0] st;
    logic [9:0] d;
    sw_wr(4'h4, {8'h00, c});
    st = 10'h000;
    for (int i = 0; i < 8 && st[0] !== 1'b1; i++)
      sw_rd(4'h5, st);
    sw_rd(4'h6, d);
    check(what, d, exp);
  endtask : expect_rd

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cycles

  task automatic test_por;
    logic [9:0] st;
    int n;
    n = 0;
    repeat (4)
    begin
      @(posedge clk);
      #1 n = n + load_output;
    end
    check("load pulses in reset", n[29:0], 30'd2);
    check("reset still active", por_active, 1'b1);
    st = 10'h004;
    for (int i = 0; i < 40 && st[2] !== 1'b0; i++)
      sw_rd(4'h5, st);
    check("reset finished", por_active, 1'b0);
    n = 0;
    repeat (64)
    begin
      @(posedge clk);
      #1 n = n + prg_out;
    end
    check("clock pulses at thirty-two", n[29:0], 30'd2);
    $display("test power-on done");
  endtask : test_por

  task automatic test_defaults;
    expect_rd(2'h3, 10'h0ff, "mode reset");
    for (int i = 5; i < 8; i++)
    begin
      wreg(2'h0, i[9:0]);
      expect_rd(2'h2, (i == 5) ? 10'h000 : 10'h0ff, "command reset");
    end
    wreg(2'h0, 10'h05a);
    expect_rd(2'h0, 10'h05a, "pointer");
    $display("test defaults done");
  endtask : test_defaults

  task automatic test_mode;
    int c;
    // Reserved upper bits are written as ones and must read back zero.
    wreg(2'h3, 10'h3cf);
    expect_rd(2'h3, 10'h0cf, "mode readback");
    check("normal mode", normal_mode, 1'b1);
    c = cal_pulses;
    wreg(2'h3, 10'h0ef);
    wreg(2'h3, 10'h0cf);
    wait_cycles(3);
    check("calibrate pulses", 30'(cal_pulses - c), 30'd1);
    @(posedge clk);
    ps_lo <= 1'b0;
    wait_cycles(2);
    check("video when unmatched", video_enable, 1'b0);
    check("dac when unmatched", dac_word, 30'h0);
    @(posedge clk);
    ps_lo <= 1'b1;
    wait_cycles(2);
    check("video when matched", video_enable, 1'b1);
    // The second pass starts an odd number of cycles later, so a free
    // running phase cannot read as restarted both times.
    for (int k = 0; k < 2; k++)
    begin
      wreg(2'h3, 10'h0ce);
      wreg(2'h3, 10'h0cf);
      wait_cycles(1);
      check("phase after restart", phase_b, 1'b0);
      wait_cycles(1);
      check("phase one cycle on", phase_b, 1'b1);
      wait_cycles(1);
    end
    $display("test mode done");
  endtask : test_mode

  task automatic pal_run(input logic [9:0] mode, input logic narrow,
    input logic lowres);
    logic [9:0] v [6];
    logic [9:0] e;
    v = '{10'h3a5, 10'h1c3, 10'h2f0, 10'h0ab, 10'h3ff, 10'h100};
    wreg(2'h3, mode);
    wreg(2'h0, 10'h010);
    foreach (v[i])
      if (narrow)
      begin
        wreg(2'h1, {2'h0, v[i][9:2]});
        wreg(2'h1, {8'h00, v[i][1:0]});
      end
      else
        wreg(2'h1, v[i]);
    wreg(2'h0, 10'h010);
    foreach (v[i])
    begin
      e = lowres ? (v[i] & 10'h3fc) : v[i];
      if (narrow)
      begin
        expect_rd(2'h1, {2'h0, e[9:2]}, "palette high");
        expect_rd(2'h1, {8'h00, e[1:0]}, "palette low");
      end
      else
        expect_rd(2'h1, e, "palette word");
    end
    expect_rd(2'h0, 10'h012, "pointer after triples");
  endtask : pal_run

  task automatic test_palette;
    pal_run(10'h0cf, 1'b0, 1'b0);
    pal_run(10'h0cd, 1'b0, 1'b1);
    pal_run(10'h0cb, 1'b1, 1'b0);
    $display("test palette done");
  endtask : test_palette

  task automatic test_control;
    wreg(2'h3, 10'h0cf);
    wreg(2'h0, 10'h000);
    expect_rd(2'h2, 10'h010, "pixel red");
    expect_rd(2'h2, 10'h034, "pixel green");
    expect_rd(2'h2, 10'h056, "pixel blue");
    wreg(2'h0, 10'h001);
    expect_rd(2'h2, 10'h3a5, "converter red");
    expect_rd(2'h2, 10'h1c3, "converter green");
    expect_rd(2'h2, 10'h2f0, "converter blue");
    wreg(2'h0, 10'h008);
    wreg(2'h2, 10'h055);
    expect_rd(2'h2, 10'h000, "unassigned index");
    $display("test control done");
  endtask : test_control

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    test_por();
    test_defaults();
    test_mode();
    test_palette();
    test_control();
    give_verdict();
  end
endmodule : palette_dac_host_port_test
